// *** inc/irh_params.svh ***
// constants of the interrupt mask and holding register bank
// Overview of operation
// - a one written to an enable-set bit sets that mask bit only.
// - a one written to an enable-clear bit clears that mask bit only.
// - zeros written to enable-set or enable-clear change no mask bit.
// - a mask bit of one enables its source; only those two writes and reset move it.
// - receive word available, overflow and dma done sit at bits 1, 2, 3.
// - transmit slot free, starved and dma done sit at bits 5, 6, 7.
// - receive buffer full sits at bit 19, transmit empty at bit 31.
// - each newly received word is loaded into the receive holding word.
// - received words shorter than 32 bits are right-justified.
// - a transmit word goes out next; software writes it while slot free.
// - receive word available sets on a new word, clears when it is read.
// - transmit slot free clears on a write, sets when the word is taken.
`ifndef IRH_PARAMS_SVH
`define IRH_PARAMS_SVH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define IRH_A_CFG    32'h4000_0004
`define IRH_A_FLAG   32'h4000_0008
`define IRH_A_FCLR   32'h4000_000C
`define IRH_A_IER    32'h4000_0014
`define IRH_A_IDR    32'h4000_0018
`define IRH_A_IMR    32'h4000_001C
`define IRH_A_RXHOLD 32'h4000_0020
`define IRH_A_TXHOLD 32'h4000_0024
// ----------------------------------------------------------------------
// flag bit positions, shared by flag, enable and mask registers
// ----------------------------------------------------------------------
`define IRH_B_RXAVAIL   1
`define IRH_B_RXOVF     2
`define IRH_B_RXDONE    3
`define IRH_B_TXFREE    5
`define IRH_B_TXSTARVE  6
`define IRH_B_TXDONE    7
`define IRH_B_RXBUFFULL 19
`define IRH_B_TXEMP  31
`define IRH_SRC_BITS 32'h8008_00EE
`define IRH_STICKY   32'h0000_00CC
// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define IRH_ZERO     32'h0000_0000
`define IRH_CFG_RST  5'h1F
`define IRH_OKAY     2'h0
`define IRH_SLVERR   2'h2
`endif

// *** inc/irh_pkg.sv ***
// types and helpers of the interrupt mask and holding register bank
package irh_pkg;
  typedef logic [31:0] irh_word_t;
  typedef logic [4:0]  irh_width_t;
  typedef logic [1:0]  irh_resp_t;

  // keeps the low (width+1) bits of a sample, code 31 means 32 bits
  function automatic irh_word_t width_mask(irh_width_t w);
    irh_word_t m;
    m = ~(irh_word_t'(32'hFFFF_FFFE) << w);
    return m;
  endfunction
endpackage

// *** inc/irh_hold_if.sv ***
// carrier between the register bank and its two holding registers
`timescale 1ns/1ps
interface irh_hold_if;
  irh_pkg::irh_width_t width;
  logic                rx_load;
  irh_pkg::irh_word_t  rx_data;
  logic                rx_read;
  logic                rx_full;
  irh_pkg::irh_word_t  rx_word;
  logic                rx_over;
  logic                tx_write;
  irh_pkg::irh_word_t  tx_data;
  logic                tx_take;
  logic                tx_empty;
  irh_pkg::irh_word_t  tx_word;
  logic                tx_starve;

  modport rxm (input width, rx_load, rx_data, rx_read,
               output rx_full, rx_word, rx_over);
  modport txm (input width, tx_write, tx_data, tx_take,
               output tx_empty, tx_word, tx_starve);
  modport top (output width, rx_load, rx_data, rx_read, tx_write,
               tx_data, tx_take,
               input rx_full, rx_word, rx_over, tx_empty, tx_word,
               tx_starve);
endinterface // irh_hold_if

// *** rtl/irh_rx_hold.sv ***
// receive holding word and its availability flag
`timescale 1ns/1ps
`include "irh_params.svh"
module irh_rx_hold (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  irh_hold_if.rxm  hif
);
  irh_pkg::irh_word_t word_ff;
  irh_pkg::irh_word_t nxt_word_ff;
  logic               full_ff;
  logic               nxt_full_ff;

  always_comb begin
    nxt_word_ff = word_ff;
    nxt_full_ff = full_ff;
    if (hif.rx_read) begin
      nxt_full_ff = 1'b0;
    end
    if (hif.rx_load) begin
      // a new word wins over a read in the same cycle
      nxt_word_ff = hif.rx_data & irh_pkg::width_mask(hif.width);
      nxt_full_ff = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_ff <= `IRH_ZERO;
      full_ff <= 1'b0;
    end else if (ce) begin
      word_ff <= nxt_word_ff;
      full_ff <= nxt_full_ff;
    end
  end

  assign hif.rx_word = word_ff;
  assign hif.rx_full = full_ff;
  assign hif.rx_over = hif.rx_load && full_ff && !hif.rx_read;

  a_rx_word_load: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && hif.rx_load) |=> (word_ff == ($past(hif.rx_data) &
      irh_pkg::width_mask($past(hif.width)))))
    else $error("receive word not loaded right-justified");
endmodule // irh_rx_hold

// *** rtl/irh_tx_hold.sv ***
// transmit holding word and its slot-free flag
`timescale 1ns/1ps
`include "irh_params.svh"
module irh_tx_hold (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  irh_hold_if.txm  hif
);
  irh_pkg::irh_word_t word_ff;
  irh_pkg::irh_word_t nxt_word_ff;
  logic               empty_ff;
  logic               nxt_empty_ff;

  always_comb begin
    nxt_word_ff  = word_ff;
    nxt_empty_ff = empty_ff;
    if (hif.tx_take) begin
      nxt_empty_ff = 1'b1;
    end
    if (hif.tx_write) begin
      // a write while full replaces the waiting word: software must not
      nxt_word_ff  = hif.tx_data & irh_pkg::width_mask(hif.width);
      nxt_empty_ff = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_ff  <= `IRH_ZERO;
      empty_ff <= 1'b1;
    end else if (ce) begin
      word_ff  <= nxt_word_ff;
      empty_ff <= nxt_empty_ff;
    end
  end

  assign hif.tx_word   = word_ff;
  assign hif.tx_empty  = empty_ff;
  assign hif.tx_starve = hif.tx_take && empty_ff;

  a_tx_write_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && hif.tx_write) |=> (!empty_ff && word_ff ==
      ($past(hif.tx_data) & irh_pkg::width_mask($past(hif.width)))))
    else $error("transmit write did not fill the holding word");
endmodule // irh_tx_hold

// *** rtl/irh_top.sv ***
// interrupt mask and holding register bank behind an axi4-lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "irh_params.svh"
module irh_top (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  input  wire irh_pkg::irh_word_t  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire irh_pkg::irh_word_t  s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output irh_pkg::irh_resp_t       s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire irh_pkg::irh_word_t  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output irh_pkg::irh_word_t       s_axi_rdata,
  output irh_pkg::irh_resp_t       s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                rx_word_valid,
  input  wire irh_pkg::irh_word_t  rx_word,
  input  wire logic                rx_dma_done,
  input  wire logic                tx_dma_done,
  input  wire logic                tx_take,
  output irh_pkg::irh_word_t       tx_word,
  output logic                     tx_word_valid,
  output logic                     irq
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                aw_got_ff, nxt_aw_got_ff;
  irh_pkg::irh_word_t  awaddr_ff, nxt_awaddr_ff;
  logic                w_got_ff, nxt_w_got_ff;
  irh_pkg::irh_word_t  wdata_ff, nxt_wdata_ff;
  logic                bvalid_ff, nxt_bvalid_ff;
  irh_pkg::irh_resp_t  bresp_ff, nxt_bresp_ff;
  logic                rvalid_ff, nxt_rvalid_ff;
  irh_pkg::irh_word_t  rdata_ff, nxt_rdata_ff;
  irh_pkg::irh_resp_t  rresp_ff, nxt_rresp_ff;
  irh_pkg::irh_word_t  mask_ff, nxt_mask_ff;
  irh_pkg::irh_word_t  sticky_ff, nxt_sticky_ff;
  irh_pkg::irh_width_t cfg_ff, nxt_cfg_ff;
  logic                irq_ff, nxt_irq_ff;

  logic                wr_fire;
  logic                rd_fire;
  logic                ier_wr;
  logic                idr_wr;
  irh_pkg::irh_word_t  wd_bits;
  irh_pkg::irh_word_t  flags;
  irh_pkg::irh_word_t  events;
  irh_hold_if          hif ();

  function automatic logic mapped(irh_pkg::irh_word_t a);
    return a == `IRH_A_CFG || a == `IRH_A_FLAG || a == `IRH_A_FCLR ||
           a == `IRH_A_IER || a == `IRH_A_IDR  || a == `IRH_A_IMR  ||
           a == `IRH_A_RXHOLD || a == `IRH_A_TXHOLD;
  endfunction

  // ----------------------------------------------------------------------
  // holding registers
  // ----------------------------------------------------------------------
  irh_rx_hold u_rx (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .hif     (hif.rxm)
  );

  irh_tx_hold u_tx (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .hif     (hif.txm)
  );

  assign hif.width    = cfg_ff;
  assign hif.rx_load  = rx_word_valid;
  assign hif.rx_data  = rx_word;
  assign hif.rx_read  = rd_fire && s_axi_araddr == `IRH_A_RXHOLD;
  assign hif.tx_write = wr_fire && awaddr_ff == `IRH_A_TXHOLD;
  assign hif.tx_data  = wdata_ff;
  assign hif.tx_take  = tx_take;
  assign tx_word       = hif.tx_word;
  assign tx_word_valid = !hif.tx_empty;

  // ----------------------------------------------------------------------
  // flag vector, same layout as the enable and mask registers
  // ----------------------------------------------------------------------
  always_comb begin
    events = `IRH_ZERO;
    events[`IRH_B_RXOVF]    = hif.rx_over;
    events[`IRH_B_RXDONE]   = rx_dma_done;
    events[`IRH_B_TXSTARVE] = hif.tx_starve;
    events[`IRH_B_TXDONE]   = tx_dma_done;
    flags = sticky_ff;
    flags[`IRH_B_RXAVAIL]   = hif.rx_full;
    flags[`IRH_B_RXBUFFULL] = hif.rx_full;
    flags[`IRH_B_TXFREE]    = hif.tx_empty;
    flags[`IRH_B_TXEMP]  = hif.tx_empty;
  end

  // ----------------------------------------------------------------------
  // bus handshake and register writes
  // ----------------------------------------------------------------------
  assign s_axi_awready = ce && !aw_got_ff;
  assign s_axi_wready  = ce && !w_got_ff;
  assign s_axi_arready = ce && !rvalid_ff;
  assign wr_fire = ce && aw_got_ff && w_got_ff && !bvalid_ff;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign ier_wr  = wr_fire && awaddr_ff == `IRH_A_IER;
  assign idr_wr  = wr_fire && awaddr_ff == `IRH_A_IDR;
  // unused positions are dropped so they can never enable anything
  assign wd_bits = wdata_ff & `IRH_SRC_BITS;

  always_comb begin
    nxt_aw_got_ff = aw_got_ff;
    nxt_awaddr_ff = awaddr_ff;
    nxt_w_got_ff  = w_got_ff;
    nxt_wdata_ff  = wdata_ff;
    nxt_bvalid_ff = bvalid_ff;
    nxt_bresp_ff  = bresp_ff;
    nxt_mask_ff   = mask_ff;
    nxt_sticky_ff = sticky_ff;
    nxt_cfg_ff    = cfg_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_got_ff = 1'b1;
      nxt_awaddr_ff = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_got_ff = 1'b1;
      for (int i = 0; i < 4; i++) begin
        nxt_wdata_ff[8*i +: 8] = s_axi_wstrb[i] ? s_axi_wdata[8*i +: 8]
                                                : 8'h00;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bvalid_ff = 1'b0;
    end
    if (wr_fire) begin
      nxt_aw_got_ff = 1'b0;
      nxt_w_got_ff  = 1'b0;
      nxt_bvalid_ff = 1'b1;
      nxt_bresp_ff  = mapped(awaddr_ff) ? `IRH_OKAY : `IRH_SLVERR;
      if (awaddr_ff == `IRH_A_CFG) begin
        nxt_cfg_ff = wdata_ff[4:0];
      end
      if (awaddr_ff == `IRH_A_FCLR) begin
        nxt_sticky_ff = sticky_ff & ~wdata_ff;
      end
    end
    if (ier_wr) begin
      nxt_mask_ff = mask_ff | wd_bits;
    end
    if (idr_wr) begin
      nxt_mask_ff = mask_ff & ~wd_bits;
    end
    // an event in the clearing cycle survives the clear
    nxt_sticky_ff = (nxt_sticky_ff | events) & `IRH_STICKY;
    nxt_irq_ff    = |(flags & mask_ff);
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_rvalid_ff = rvalid_ff;
    nxt_rdata_ff  = rdata_ff;
    nxt_rresp_ff  = rresp_ff;
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_rvalid_ff = 1'b0;
    end
    if (rd_fire) begin
      nxt_rvalid_ff = 1'b1;
      nxt_rresp_ff  = mapped(s_axi_araddr) ? `IRH_OKAY : `IRH_SLVERR;
      case (s_axi_araddr)
        `IRH_A_CFG:  nxt_rdata_ff = {27'h000_0000, cfg_ff};
        `IRH_A_FLAG: nxt_rdata_ff = flags;
        `IRH_A_IMR:  nxt_rdata_ff = mask_ff;
        `IRH_A_RXHOLD: nxt_rdata_ff = hif.rx_word;
        default:     nxt_rdata_ff = `IRH_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= `IRH_ZERO;
      w_got_ff  <= 1'b0;
      wdata_ff  <= `IRH_ZERO;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `IRH_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= `IRH_ZERO;
      rresp_ff  <= `IRH_OKAY;
      mask_ff   <= `IRH_ZERO;
      sticky_ff <= `IRH_ZERO;
      cfg_ff    <= `IRH_CFG_RST;
      irq_ff    <= 1'b0;
    end else if (ce) begin
      aw_got_ff <= nxt_aw_got_ff;
      awaddr_ff <= nxt_awaddr_ff;
      w_got_ff  <= nxt_w_got_ff;
      wdata_ff  <= nxt_wdata_ff;
      bvalid_ff <= nxt_bvalid_ff;
      bresp_ff  <= nxt_bresp_ff;
      rvalid_ff <= nxt_rvalid_ff;
      rdata_ff  <= nxt_rdata_ff;
      rresp_ff  <= nxt_rresp_ff;
      mask_ff   <= nxt_mask_ff;
      sticky_ff <= nxt_sticky_ff;
      cfg_ff    <= nxt_cfg_ff;
      irq_ff    <= nxt_irq_ff;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
  assign irq          = irq_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ier_sets_mask: assert property ((ce && ier_wr) |=>
    ((mask_ff & $past(wd_bits)) == $past(wd_bits)) &&
    ((mask_ff & ~$past(wd_bits)) == ($past(mask_ff) & ~$past(wd_bits))))
    else $error("enable-set write did not set just its bits");
  a_idr_clears_mask: assert property ((ce && idr_wr) |=>
    ((mask_ff & $past(wd_bits)) == `IRH_ZERO) &&
    ((mask_ff | $past(wd_bits)) == ($past(mask_ff) | $past(wd_bits))))
    else $error("enable-clear write did not clear just its bits");
  a_mask_only_writes: assert property ((!ce || (!ier_wr && !idr_wr)) |=>
    $stable(mask_ff))
    else $error("mask moved without an enable write");
  a_mask_bit_layout: assert property (
    (mask_ff & ~`IRH_SRC_BITS) == `IRH_ZERO)
    else $error("mask bit outside the source positions");
  a_rxhold_read_clears: assert property ((ce && hif.rx_read &&
    !rx_word_valid) |=> !flags[`IRH_B_RXAVAIL])
    else $error("receive flag survived a read");
  a_irq_has_cause: assert property ($rose(irq) |->
    $past(|(flags & mask_ff)))
    else $error("interrupt rose with no enabled flag");
  a_irq_drops: assert property ((ce && !(|(flags & mask_ff))) |=>
    !irq)
    else $error("interrupt held with no enabled flag");
  a_reset_mask_zero: assert property (@(posedge clk) disable iff (1'b0)
    !reset_n |=> (mask_ff == `IRH_ZERO && !irq))
    else $error("mask not clear after reset");
  a_txhold_write_busy: assert property ((ce && hif.tx_write) |=>
    !flags[`IRH_B_TXFREE])
    else $error("slot-free flag set after a transmit write");

  c_ier_write: cover property (ce && ier_wr);
  c_rxhold_read: cover property (ce && hif.rx_read && hif.rx_full);
  c_irq_rise: cover property ($rose(irq));
  c_tx_starve: cover property (ce && hif.tx_starve);
endmodule // irh_top

// *** tb/irh_top_tb.sv ***
// self-checking bench of the interrupt mask and holding register bank
`timescale 1ns/1ps
`include "irh_params.svh"
module irh_top_tb;
  // --------------------------------------------------------------------
  // clock, reset and design ports
  // --------------------------------------------------------------------
  logic               clk;
  logic               reset_n;
  logic               ce;
  irh_pkg::irh_word_t awaddr, wdata, araddr, rdata, rx_word, tx_word;
  logic [3:0]         wstrb;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  irh_pkg::irh_resp_t bresp, rresp, resp;
  logic               rx_word_valid, rx_dma_done, tx_dma_done, tx_take;
  logic               tx_word_valid, irq;
  irh_pkg::irh_word_t rd;
  int                 error_cnt, n_checks, cyc;

  irh_top uut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_dma_done(rx_dma_done), .tx_dma_done(tx_dma_done),
    .tx_take(tx_take), .tx_word(tx_word), .tx_word_valid(tx_word_valid),
    .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input irh_pkg::irh_word_t seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask

  // address and data are offered together, each released once taken
  task automatic wr(input irh_pkg::irh_word_t a, d);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input irh_pkg::irh_word_t a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // sel: rx word, rx dma done, tx dma done, tx take
  task automatic pulse(input logic [3:0] sel, input irh_pkg::irh_word_t w);
    rx_word <= w;
    {rx_word_valid, rx_dma_done, tx_dma_done, tx_take} <= sel;
    @(posedge clk);
    {rx_word_valid, rx_dma_done, tx_dma_done, tx_take} <= 4'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  int bits [8] = '{1, 2, 3, 5, 6, 7, 19, 31};

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {rx_word_valid, rx_dma_done, tx_dma_done, tx_take} = 4'h0;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    araddr = 32'h0000_0000;
    rx_word = 32'h0000_0000;
    wstrb = 4'hF;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    do_reset();
    rd_reg(`IRH_A_IMR); chk(rd, 32'h0000_0000);
    chk_irq(1'b0);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8000_0020);
    wr(`IRH_A_IER, 32'hFFFF_FFFF);
    rd_reg(`IRH_A_IMR); chk(rd, 32'h8008_00EE);
    chk_irq(1'b1);
    wr(`IRH_A_IDR, 32'h8000_0020);
    rd_reg(`IRH_A_IMR); chk(rd, 32'h0008_00CE);
    chk_irq(1'b0);
    wr(`IRH_A_IER, 32'h0000_0000);
    wr(`IRH_A_IDR, 32'h0000_0000);
    rd_reg(`IRH_A_IMR); chk(rd, 32'h0008_00CE);
    // each source alone, so a swapped position cannot hide
    foreach (bits[i]) begin
      wr(`IRH_A_IDR, 32'hFFFF_FFFF);
      wr(`IRH_A_IER, 32'h0000_0001 << bits[i]);
      rd_reg(`IRH_A_IMR); chk(rd, 32'h0000_0001 << bits[i]);
    end
    wr(`IRH_A_IER, 32'h0000_0002);
    rd_reg(`IRH_A_IMR); chk(rd, 32'h8000_0002);
    wr(`IRH_A_IDR, 32'h8000_0000);
    // receive path at the reset width of 32 bits
    pulse(4'h8, 32'hDEAD_BEEF);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8008_0022);
    chk_irq(1'b1);
    rd_reg(`IRH_A_RXHOLD); chk(rd, 32'hDEAD_BEEF);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8000_0020);
    chk_irq(1'b0);
    // 16-bit samples: right-justified, newest word kept
    wr(`IRH_A_CFG, 32'h0000_000F);
    pulse(4'h8, 32'h1234_ABCD);
    rd_reg(`IRH_A_RXHOLD); chk(rd, 32'h0000_ABCD);
    pulse(4'h8, 32'h1111_2222);
    pulse(4'h8, 32'hFFFF_3333);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8008_0026);
    rd_reg(`IRH_A_RXHOLD); chk(rd, 32'h0000_3333);
    wr(`IRH_A_FCLR, 32'h0000_0004);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8000_0020);
    // transmit path
    wr(`IRH_A_TXHOLD, 32'h0000_1234);
    @(posedge clk);
    chk(tx_word, 32'h0000_1234);
    chk({31'h0, tx_word_valid}, 32'h0000_0001);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h0000_0000);
    pulse(4'h1, 32'h0000_0000);
    chk({31'h0, tx_word_valid}, 32'h0000_0000);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8000_0020);
    pulse(4'h1, 32'h0000_0000);
    pulse(4'h6, 32'h0000_0000);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8000_00E8);
    wr(`IRH_A_IER, 32'h0000_0040);
    chk_irq(1'b1);
    wr(`IRH_A_FCLR, 32'h0000_00CC);
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8000_0020);
    chk_irq(1'b0);
    // a word offered while the enable is low must be ignored
    ce <= 1'b0;
    pulse(4'h8, 32'h5555_AAAA);
    ce <= 1'b1;
    rd_reg(`IRH_A_FLAG); chk(rd, 32'h8000_0020);
    // unmapped and write-only places
    wr(32'h4000_0030, 32'hFFFF_FFFF);
    chk({30'h0, resp}, {30'h0, `IRH_SLVERR});
    rd_reg(32'h4000_0030);
    chk({30'h0, resp}, {30'h0, `IRH_SLVERR});
    chk(rd, 32'h0000_0000);
    rd_reg(`IRH_A_IER); chk(rd, 32'h0000_0000);
    rd_reg(`IRH_A_IMR); chk(rd, 32'h0000_0042);
    // reset in mid-run drops every mask bit
    wr(`IRH_A_IER, 32'hFFFF_FFFF);
    do_reset();
    rd_reg(`IRH_A_IMR); chk(rd, 32'h0000_0000);
    complete_run();
  end
endmodule // irh_top_tb
